// ---- rtl/blt_defines.svh ----
// Constants for the backplane block transfer slave.
// Included by the slave and the bench; definitions only.
`ifndef BLT_DEFINES_SVH
`define BLT_DEFINES_SVH

`define BLT_AM_A16        6'h29
`define BLT_AM_A24        6'h39
`define BLT_AM_A24_BLT    6'h3b
`define BLT_AM_A32        6'h09
`define BLT_AM_A32_BLT    6'h0b

`define BLT_LANE_B0       4'h1
`define BLT_LANE_B1       4'h2
`define BLT_LANE_B2       4'h4
`define BLT_LANE_B3       4'h8
`define BLT_LANE_B01      4'h3
`define BLT_LANE_B23      4'hc
`define BLT_LANE_QUAD     4'hf
`define BLT_LANE_NONE     4'h0

`define BLT_SPACE16_MASK  32'h0000_ffff
`define BLT_SPACE24_MASK  32'h00ff_ffff
`define BLT_SPACE32_MASK  32'hffff_ffff
`define BLT_BOUND_BITS    8
`define BLT_FIFO_DEPTH    4

`define BLT_BASE16        32'h0000_c000
`define BLT_BASE24        32'h0020_0000
`define BLT_BASE32        32'h8000_0000
`define BLT_MATCH_LSB     12

`endif

// ---- rtl/blt_pkg.sv ----
// Types shared by the block transfer slave and its user side.
// Assumes blt_defines.svh is on the include path.
package blt_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_BEAT = 3'b001,
    ST_WR   = 3'b010,
    ST_RD   = 3'b011,
    ST_ACK  = 3'b100,
    ST_SKIP = 3'b101
  } slave_state_t;

  typedef enum logic [1:0]
  {
    AM_NONE  = 2'b00,
    AM_SHORT = 2'b01,
    AM_STD   = 2'b10,
    AM_EXT   = 2'b11
  } am_space_t;

  typedef struct packed
  {
    logic        as_n;
    logic [1:0]  ds_n;
    logic        lword_n;
    logic        write_n;
    logic        iack_n;
    logic [5:0]  am;
    logic [31:1] addr;
  } bus_ctl_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [3:0]  lanes;
    logic [31:0] data;
  } wr_entry_t;
endpackage

// ---- rtl/blt_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module blt_fifo
#(
  parameter int WIDTH = 68,
  parameter int DEPTH = 4
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("blt_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];

  // Storage carries no reset; only the pointers define contents
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg  <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

// ---- rtl/blt_slave.sv ----
// Backplane data transfer slave with block transfer support.
// Assumes bus strobes already synchronous to i_clk and a user
// side that drains writes and answers reads.
`timescale 1ns/1ps
`include "blt_defines.svh"

// Operation
// - Byte-capable slave serves single bytes, lanes 0-3; odd-only 1, 3.
// - Serve double bytes at 0-1 and 2-3, quad at 0-3 when enabled.
// - Monitor pulse reports every accepted cycle of this width class.
// - On every address strobe fall seen in the idle state the slave loads the address counter, selected or not.
// - Counter advances once per completed data strobe beat of a block cycle; single cycles hold it.
// - Upper address decoded once at block start; only low bits step.
// - Block beats act as ordinary cycles under one held address strobe.
// - Cycles with interrupt acknowledge low are ignored.
// - All six address modifier lines decode the address space.
module blt_slave
#(
  parameter logic [31:0] BASE16    = `BLT_BASE16,
  parameter logic [31:0] BASE24    = `BLT_BASE24,
  parameter logic [31:0] BASE32    = `BLT_BASE32,
  parameter int          MATCH_LSB = `BLT_MATCH_LSB,
  parameter bit          ODD_ONLY  = 1'b0,
  parameter bit          D32_EN    = 1'b1,
  parameter int          DEPTH     = `BLT_FIFO_DEPTH
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire blt_pkg::bus_ctl_t i_bus,
  input  wire logic [31:0]       i_data,
  output logic      [31:0]       o_data,
  output logic                   o_data_oe_n,
  output logic                   o_dtack_n,
  output logic                   o_wr_valid,
  output blt_pkg::wr_entry_t     o_wr_entry,
  input  wire logic              i_wr_ready,
  output logic                   o_rd_req,
  output logic      [31:0]       o_rd_addr,
  output logic      [3:0]        o_rd_lanes,
  input  wire logic              i_rd_valid,
  input  wire logic [31:0]       i_rd_data,
  output logic                   o_mon_hit
);
  import blt_pkg::*;

  if (MATCH_LSB < `BLT_BOUND_BITS || MATCH_LSB > 15)
  begin : g_bad_match
    $error("blt_slave MATCH_LSB must lie in 8..15");
  end
  if (ODD_ONLY && D32_EN)
  begin : g_bad_class
    $error("blt_slave odd-only class cannot serve quad bytes");
  end

  localparam logic [31:0] MATCH_MASK =
    ~((32'h1 << MATCH_LSB) - 32'h1);

  function automatic am_space_t am_space(input logic [5:0] am);
    case (am)
      `BLT_AM_A16:     am_space = AM_SHORT;
      `BLT_AM_A24:     am_space = AM_STD;
      `BLT_AM_A24_BLT: am_space = AM_STD;
      `BLT_AM_A32:     am_space = AM_EXT;
      `BLT_AM_A32_BLT: am_space = AM_EXT;
      default:         am_space = AM_NONE;
    endcase
  endfunction

  function automatic logic am_block(input logic [5:0] am);
    am_block = (am == `BLT_AM_A24_BLT) || (am == `BLT_AM_A32_BLT);
  endfunction

  function automatic logic [3:0] lane_decode(input logic [1:0] ds_n,
                                             input logic       a01,
                                             input logic       lword_n);
    case ({ds_n, a01, lword_n})
      4'b0101: lane_decode = `BLT_LANE_B0;
      4'b1001: lane_decode = `BLT_LANE_B1;
      4'b0111: lane_decode = `BLT_LANE_B2;
      4'b1011: lane_decode = `BLT_LANE_B3;
      4'b0001: lane_decode = `BLT_LANE_B01;
      4'b0011: lane_decode = `BLT_LANE_B23;
      4'b0000: lane_decode = `BLT_LANE_QUAD;
      default: lane_decode = `BLT_LANE_NONE;
    endcase
  endfunction

  function automatic logic [2:0] lane_count(input logic [3:0] lanes);
    case (lanes)
      `BLT_LANE_QUAD: lane_count = 3'h4;
      `BLT_LANE_B01:  lane_count = 3'h2;
      `BLT_LANE_B23:  lane_count = 3'h2;
      default:        lane_count = 3'h1;
    endcase
  endfunction

  slave_state_t state_reg;
  slave_state_t state_next;
  logic         as_prev_reg;
  logic         blk_reg;
  logic         write_reg;
  logic [31:0]  addr_reg;
  logic [31:0]  addr_next;
  logic [3:0]   lanes_reg;
  logic [31:0]  wdata_reg;
  logic [31:0]  rdata_reg;
  logic         mon_reg;

  logic         as_fall;
  logic         ds_any_low;
  logic         ds_all_high;
  logic [31:0]  bus_addr;
  am_space_t    space;
  logic [31:0]  space_mask;
  logic         base_hit;
  logic         sel_hit;
  logic [3:0]   lanes_now;
  logic         lanes_ok;
  logic         load_addr;
  logic         beat_go;
  logic         beat_done;
  logic [2:0]   step_w;
  logic         fifo_in_ready;
  logic [31:0]  base_sel;

  assign as_fall     = as_prev_reg & ~i_bus.as_n;
  assign ds_any_low  = ~&i_bus.ds_n;
  assign ds_all_high = &i_bus.ds_n;
  assign bus_addr    = {i_bus.addr, 1'b0};
  assign space       = am_space(i_bus.am);
  assign space_mask  = (space == AM_SHORT) ? `BLT_SPACE16_MASK :
                       (space == AM_STD)   ? `BLT_SPACE24_MASK :
                                             `BLT_SPACE32_MASK;
  assign base_sel    = (space == AM_SHORT) ? BASE16 :
                       (space == AM_STD)   ? BASE24 : BASE32;
  // Full decode only here, so later beats see no decode delay
  assign base_hit    = ((bus_addr ^ base_sel) & MATCH_MASK
                        & space_mask) == 32'h0;
  assign sel_hit     = (space != AM_NONE) & i_bus.iack_n
                       & base_hit;
  assign lanes_now   = lane_decode(i_bus.ds_n, addr_reg[1],
                                   i_bus.lword_n);
  // The same filter drives acceptance and the monitor pulse
  assign lanes_ok    = ODD_ONLY ?
                       (lanes_now == `BLT_LANE_B1 ||
                        lanes_now == `BLT_LANE_B3) :
                       (lanes_now != `BLT_LANE_NONE &&
                        (D32_EN ||
                         lanes_now != `BLT_LANE_QUAD));
  assign load_addr   = (state_reg == ST_IDLE) & as_fall;
  assign beat_go     = (state_reg == ST_BEAT) & ds_any_low & lanes_ok;
  assign beat_done   = (state_reg == ST_ACK) & ds_all_high;
  assign step_w      = lane_count(lanes_reg);
  // Only the low byte steps; the upper bits stay put across a block
  assign addr_next   = load_addr ? bus_addr :
                       (beat_done & blk_reg) ?
                       {addr_reg[31:8],
                        addr_reg[7:0] + {5'h0, step_w}} :
                       addr_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (as_fall)
          state_next = sel_hit ? ST_BEAT : ST_SKIP;
      ST_BEAT:
        if (i_bus.as_n)
          state_next = ST_IDLE;
        else if (ds_any_low)
          state_next = !lanes_ok ? ST_SKIP :
                       i_bus.write_n ? ST_RD : ST_WR;
      ST_WR:
        if (fifo_in_ready)
          state_next = ST_ACK;
      ST_RD:
        if (i_rd_valid)
          state_next = ST_ACK;
      ST_ACK:
        if (ds_all_high)
          state_next = (blk_reg & ~i_bus.as_n) ? ST_BEAT :
                       i_bus.as_n ? ST_IDLE : ST_SKIP;
      ST_SKIP:
        if (i_bus.as_n)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg   <= ST_IDLE;
      as_prev_reg <= 1'b0;
      blk_reg     <= 1'b0;
      addr_reg    <= 32'h0;
      mon_reg     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      as_prev_reg <= i_bus.as_n;
      blk_reg     <= load_addr ? am_block(i_bus.am) : blk_reg;
      addr_reg    <= addr_next;
      mon_reg     <= beat_done;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      write_reg <= 1'b0;
      lanes_reg <= 4'h0;
      wdata_reg <= 32'h0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      write_reg <= beat_go ? ~i_bus.write_n : write_reg;
      lanes_reg <= beat_go ? lanes_now : lanes_reg;
      wdata_reg <= beat_go ? i_data : wdata_reg;
      rdata_reg <= (state_reg == ST_RD && i_rd_valid) ? i_rd_data
                                                      : rdata_reg;
    end
  end

  // Write beats stall on a full FIFO; the master simply waits for DTACK
  blt_fifo
  #(
    .WIDTH ($bits(wr_entry_t)),
    .DEPTH (DEPTH)
  )
  u_wr_fifo
  (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (state_reg == ST_WR),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({addr_reg, lanes_reg, wdata_reg}),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (o_wr_entry)
  );

  assign o_dtack_n   = (state_reg != ST_ACK);
  assign o_data_oe_n = ~((state_reg == ST_ACK) & ~write_reg);
  assign o_data      = rdata_reg;
  assign o_rd_req    = (state_reg == ST_RD);
  assign o_rd_addr   = addr_reg;
  assign o_rd_lanes  = lanes_reg;
  assign o_mon_hit   = mon_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_iack_ignore;
    (state_reg == ST_IDLE && as_fall && !i_bus.iack_n)
      |=> (state_reg == ST_SKIP) [*1] ##1 o_dtack_n;
  endproperty
  a_iack_ignore: assert property (p_iack_ignore)
    else $error("cycle taken with interrupt acknowledge low");

  property p_load;
    load_addr |=> addr_reg == {$past(i_bus.addr), 1'b0};
  endproperty
  a_load: assert property (p_load)
    else $error("address counter not loaded at strobe fall");

  property p_hold;
    (!load_addr && !(beat_done && blk_reg)) |=> $stable(addr_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address counter moved without cause");

  property p_step;
    (beat_done && blk_reg) |=> addr_reg[7:0] ==
      $past(addr_reg[7:0]) + {5'h0, $past(step_w)};
  endproperty
  a_step: assert property (p_step)
    else $error("address counter stepped by wrong width");

  property p_upper;
    (state_reg != ST_IDLE) |=> $stable(addr_reg[31:8]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address changed inside a cycle");

  property p_odd_only;
    (ODD_ONLY && state_reg == ST_BEAT && !i_bus.as_n && ds_any_low &&
     lanes_now != `BLT_LANE_B1 && lanes_now != `BLT_LANE_B3)
      |=> state_reg == ST_SKIP;
  endproperty
  a_odd_only: assert property (p_odd_only)
    else $error("odd-only slave took an even lane access");

  property p_quad;
    (D32_EN && state_reg == ST_BEAT && !i_bus.as_n &&
     i_bus.ds_n == 2'b00 && !i_bus.lword_n && !addr_reg[1])
      |=> (state_reg == ST_WR || state_reg == ST_RD) &&
          lanes_reg == `BLT_LANE_QUAD;
  endproperty
  a_quad: assert property (p_quad)
    else $error("quad byte access not accepted");

  property p_dtack_hold;
    (!o_dtack_n && ds_any_low) |=> !o_dtack_n;
  endproperty
  a_dtack_hold: assert property (p_dtack_hold)
    else $error("acknowledge dropped while strobes low");

  property p_block_next;
    (beat_done && blk_reg && !i_bus.as_n) |=> state_reg == ST_BEAT;
  endproperty
  a_block_next: assert property (p_block_next)
    else $error("block did not wait for next beat");

  property p_mon;
    beat_done |=> o_mon_hit ##1 !o_mon_hit || beat_done;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor pulse missing for completed beat");

  c_block_two: cover property (beat_done && blk_reg ##[1:20] beat_done);
  c_read: cover property (state_reg == ST_RD ##[1:10] beat_done);
  c_skip: cover property (state_reg == ST_IDLE && as_fall && !sel_hit);
  c_stall: cover property (state_reg == ST_WR && !fifo_in_ready);
endmodule

// ---- sim/blt_master_model.sv ----
// Bus master model for the block transfer slave: single and block cycles.
// Assumes a slave answering on i_dtack_n, synchronous to i_clk.
`timescale 1ns/1ps
module blt_master_model
(
  input  wire logic              i_clk,
  output blt_pkg::bus_ctl_t      o_bus,
  output logic      [31:0]       o_data,
  input  wire logic              i_dtack_n,
  input  wire logic [31:0]       i_data,
  input  wire logic              i_data_oe_n
);
  import blt_pkg::*;
  logic [31:0] rd_q[$];
  initial
  begin
    o_bus  = {1'b1, 2'b11, 3'b111, 6'h00, 31'h0};
    o_data = 32'h0;
  end
  // Released lines show the inverse, so a stale value never matches
  task automatic xfer(input logic [5:0] am, input logic [31:0] addr,
                      input int width, input int beats, input logic wr,
                      input logic [31:0] wbase, input logic iack_n,
                      output int nack);
    logic [31:0] a;
    int          n;
    logic        ack;
    a    = addr;
    nack = 0;
    @(negedge i_clk);
    o_bus.addr    = addr[31:1];
    o_bus.am      = am;
    o_bus.iack_n  = iack_n;
    o_bus.write_n = ~wr;
    o_bus.lword_n = (width != 4);
    o_bus.as_n    = 1'b0;
    for (int b = 0; b < beats; b++)
    begin
      @(negedge i_clk);
      if (b > 0)
        o_bus.addr = ~addr[31:1];
      o_bus.ds_n = (width == 1) ? (a[0] ? 2'b10 : 2'b01) : 2'b00;
      if (wr)
        o_data = wbase + b;
      n = 0;
      @(posedge i_clk);
      while (i_dtack_n !== 1'b0 && n < 40)
      begin
        @(posedge i_clk);
        n++;
      end
      ack = (i_dtack_n === 1'b0);
      if (ack && !wr)
        rd_q.push_back(i_data_oe_n === 1'b0 ? i_data : ~i_data);
      if (ack)
        nack++;
      @(negedge i_clk);
      o_bus.ds_n = 2'b11;
      o_data     = ~o_data;
      n = 0;
      while (i_dtack_n !== 1'b1 && n < 10)
      begin
        @(negedge i_clk);
        n++;
      end
      if (!ack)
        break;
      a = a + width;
    end
    @(negedge i_clk);
    o_bus.as_n = 1'b1;
    o_bus.addr = ~o_bus.addr;
  endtask
endmodule

// ---- sim/backplane_transfer_cycles_blt_tb.sv ----
// Bench for the block transfer slave: master model on the bus, user
// side drains writes and answers reads with a running pattern.
// Assumes default design parameters and the shared constants.
`timescale 1ns/1ps
`include "blt_defines.svh"
module backplane_transfer_cycles_blt_tb;
  import blt_pkg::*;
  localparam logic [31:0] B24 = `BLT_BASE24;
  localparam logic [31:0] B32 = `BLT_BASE32;
  localparam logic [31:0] PAT = 32'hc0de_0000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_ready = 1'b0;
  logic        rd_valid = 1'b0;
  logic        drain_en = 1'b0;
  logic [31:0] rd_data = 32'h0;
  logic        oe_n, dtack_n, wr_valid, rd_req, mon_hit;
  logic [31:0] mdata, sdata, rd_addr;
  logic [3:0]  rd_lanes;
  bus_ctl_t    bus;
  wr_entry_t   wr_entry;
  wr_entry_t   wq[$];
  logic [35:0] rq[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          mon_n = 0;
  int          rd_n = 0;
  int          rd_exp = 0;
  int          nack;
  always #5 clk = ~clk;
  blt_slave dut (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
    .i_data(mdata), .o_data(sdata), .o_data_oe_n(oe_n),
    .o_dtack_n(dtack_n), .o_wr_valid(wr_valid), .o_wr_entry(wr_entry),
    .i_wr_ready(wr_ready), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .o_rd_lanes(rd_lanes), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_mon_hit(mon_hit));
  blt_master_model mst (.i_clk(clk), .o_bus(bus), .o_data(mdata),
    .i_dtack_n(dtack_n), .i_data(sdata), .i_data_oe_n(oe_n));
  always @(negedge clk)
  begin
    wr_ready <= drain_en;
    rd_valid <= rd_req;
    rd_data  <= PAT + 32'(rd_n);
  end
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1 && wr_ready)
      wq.push_back(wr_entry);
    if (rd_req === 1'b1 && rd_valid)
      rq.push_back({rd_lanes, rd_addr});
    rd_n  <= rd_n + ((rd_req === 1'b1 && rd_valid) ? 1 : 0);
    mon_n <= mon_n + (mon_hit === 1'b1 ? 1 : 0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entry address is compared on the long word; the lane mask says the rest
  task automatic chk_entry(input logic [31:0] a, input logic [3:0] l,
                           input logic [31:0] d);
    wr_entry_t e;
    e = '0;
    if (wq.size() > 0)
      e = wq.pop_front();
    chk(e.addr & 32'hffff_fffc, a & 32'hffff_fffc);
    chk({28'h0, e.lanes}, {28'h0, l});
    chk(e.data, d);
  endtask
  task automatic chk_read(input logic [31:0] a, input logic [3:0] l);
    logic [35:0] r;
    logic [31:0] d;
    r = '1;
    d = '1;
    if (rq.size() > 0)
      r = rq.pop_front();
    if (mst.rd_q.size() > 0)
      d = mst.rd_q.pop_front();
    chk(r[31:0] & 32'hffff_fffe, a & 32'hffff_fffe);
    chk({28'h0, r[35:32]}, {28'h0, l});
    chk(d, PAT + 32'(rd_exp));
    rd_exp++;
  endtask
  task automatic t_lanes();
    int         off[7] = '{0, 1, 2, 3, 0, 2, 0};
    int         wd[7] = '{1, 1, 1, 1, 2, 2, 4};
    logic [3:0] ln[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    int         m;
    for (int i = 0; i < 7; i++)
    begin
      m = mon_n;
      mst.xfer(`BLT_AM_A24, B24 + off[i], wd[i], 1, 1'b1,
               32'h1000_0000 + i, 1'b1, nack);
      chk(nack, 1);
      repeat (3) @(negedge clk);
      chk_entry(B24, ln[i], 32'h1000_0000 + i);
      mst.xfer(`BLT_AM_A24, B24 + off[i], wd[i], 1, 1'b0, 0, 1'b1, nack);
      chk_read(B24 + off[i], ln[i]);
      chk(mon_n - m, 2);
    end
    $display("test lanes done");
  endtask
  task automatic t_block();
    int m;
    m = mon_n;
    // Ends on the last long word below the 256 byte line
    mst.xfer(`BLT_AM_A24_BLT, B24 + 'hf0, 4, 4, 1'b1, 32'ha000_0000,
             1'b1, nack);
    chk(nack, 4);
    mst.xfer(`BLT_AM_A24_BLT, B24 + 'h100, 4, 2, 1'b1, 32'ha000_0004,
             1'b1, nack);
    chk(nack, 2);
    mst.xfer(`BLT_AM_A24_BLT, B24 + 'h200, 1, 4, 1'b1, 32'hb000_0000,
             1'b1, nack);
    repeat (3) @(negedge clk);
    for (int b = 0; b < 6; b++)
      chk_entry(B24 + 'hf0 + 4 * b, 4'hf, 32'ha000_0000 + b);
    for (int b = 0; b < 4; b++)
      chk_entry(B24 + 'h200, 4'h1 << b, 32'hb000_0000 + b);
    mst.xfer(`BLT_AM_A32_BLT, B32 + 'h10, 2, 3, 1'b0, 0, 1'b1, nack);
    chk_read(B32 + 'h10, 4'h3);
    chk_read(B32 + 'h12, 4'hc);
    chk_read(B32 + 'h14, 4'h3);
    chk(mon_n - m, 13);
    $display("test block done");
  endtask
  task automatic t_refuse();
    int m;
    m = mon_n;
    mst.xfer(`BLT_AM_A24, B24, 4, 1, 1'b1, 32'h1, 1'b0, nack);
    chk(nack, 0);
    mst.xfer(6'h3d, B24, 4, 1, 1'b1, 32'h2, 1'b1, nack);
    chk(nack, 0);
    mst.xfer(`BLT_AM_A24, B24 + 'h1000, 4, 1, 1'b1, 32'h3, 1'b1, nack);
    chk(nack, 0);
    mst.xfer(`BLT_AM_A24, B24 + 'h8, 4, 2, 1'b1, 32'h4, 1'b1, nack);
    chk(nack, 1);
    mst.xfer(`BLT_AM_A16, `BLT_BASE16, 2, 1, 1'b1, 32'h5, 1'b1, nack);
    chk(nack, 1);
    repeat (3) @(negedge clk);
    chk(wq.size(), 2);
    chk_entry(B24 + 'h8, 4'hf, 32'h4);
    chk_entry(`BLT_BASE16, 4'h3, 32'h5);
    chk(mon_n - m, 2);
    $display("test refuse done");
  endtask
  task automatic t_fifo();
    int k;
    drain_en <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      mst.xfer(`BLT_AM_A24, B24 + 'h40 + 4 * i, 4, 1, 1'b1,
               32'hd000_0000 + i, 1'b1, nack);
      chk(nack, 1);
    end
    fork
      mst.xfer(`BLT_AM_A24, B24 + 'h50, 4, 1, 1'b1, 32'hd000_0004, 1'b1, k);
      begin
        repeat (15) @(negedge clk);
        chk({31'h0, dtack_n}, 32'h1);
        drain_en <= 1'b1;
      end
    join
    chk(k, 1);
    repeat (3) @(negedge clk);
    chk({31'h0, wr_valid}, 32'h0);
    for (int i = 0; i < 5; i++)
      chk_entry(B24 + 'h40 + 4 * i, 4'hf, 32'hd000_0000 + i);
    $display("test fifo done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    chk({27'h0, dtack_n, oe_n, wr_valid, rd_req, mon_hit}, 32'h18);
    rst_n    = 1'b1;
    drain_en <= 1'b1;
    repeat (2) @(negedge clk);
    t_lanes();
    t_block();
    t_refuse();
    t_fifo();
    final_report();
  end
  // Whole run needs several hundred cycles; this is well beyond that
  initial
  begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    final_report();
  end
endmodule
